// >>> incu_cmp_abs_max.sv
// increment-unit slice: immediate compares, magnitude, larger-select
`timescale 1ns/1ps
`default_nettype none
module incu_cmp_abs_max
   import incu_pkg::*;
#(
   parameter int WIDTH = DATA_W
)
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire incu_pkg::incu_issue_t i_issue,
   output incu_pkg::incu_result_t o_result
);
   import incu_pkg::*;

   // ************************************************************
   // elaboration check
   // ************************************************************
   if (WIDTH != DATA_W) begin : g_bad_width
      $error("incu_cmp_abs_max supports only a 64-bit datapath");
   end

   // ************************************************************
   // decode
   // ************************************************************
   incu_op_t op;
   logic [1:0] size;
   logic simd;
   logic [7:0] eight_bit_constant;
   logic [5:0] dest;
   logic [7:0] chunk_top;
   logic [7:0] chunk_base;

   incu_decode u_decode (
      .i_instr(i_issue.instr),
      .o_op(op),
      .o_size(size),
      .o_simd(simd),
      .o_eight_bit_constant(eight_bit_constant),
      .o_dest(dest)
   );

   incu_lane_mask u_mask (
      .i_size(size),
      .i_simd(simd),
      .o_chunk_top(chunk_top),
      .o_chunk_base(chunk_base)
   );

   // ************************************************************
   // chunk helpers
   // ************************************************************
   // unsigned a<b per byte-segmented chunk; carries stop at chunk tops
   function automatic logic [7:0] chunk_below(
      input logic [63:0] a,
      input logic [63:0] b,
      input logic [7:0] top
   );
      logic [7:0] lt;
      logic [7:0] eq;
      logic run_lt;
      logic run_eq;
      lt = '0;
      eq = '0;
      run_lt = 1'b0;
      run_eq = 1'b1;
      // bytes walked from low to high; a higher differing byte overrides the lower ones
      for (int k = 0; k < 8; k++) begin
         if (a[k*8 +: 8] < b[k*8 +: 8]) begin
            run_lt = 1'b1;
         end else if (a[k*8 +: 8] > b[k*8 +: 8]) begin
            run_lt = 1'b0;
         end
         run_eq = run_eq & (a[k*8 +: 8] == b[k*8 +: 8]);
         lt[k] = run_lt;
         eq[k] = run_eq;
         if (top[k]) begin
            run_lt = 1'b0;
            run_eq = 1'b1;
         end
      end
      return lt | (eq & 8'h00);
   endfunction

   // spread a per-chunk flag from the top byte over the whole chunk
   function automatic logic [63:0] spread(
      input logic [7:0] flag,
      input logic [7:0] top
   );
      logic [63:0] r;
      logic cur;
      r = '0;
      cur = 1'b0;
      for (int k = 7; k >= 0; k--) begin
         if (top[k]) begin
            cur = flag[k];
         end
         r[k*8 +: 8] = {8{cur}};
      end
      return r;
   endfunction

   // ************************************************************
   // operand shaping
   // ************************************************************
   logic [63:0] imm_wide;
   logic [63:0] src;
   logic [63:0] other;

   // constant placed in each chunk's low byte, zero above
   always_comb begin
      imm_wide = '0;
      for (int k = 0; k < 8; k++) begin
         if (chunk_base[k]) begin
            imm_wide[k*8 +: 8] = eight_bit_constant;
         end
      end
   end

   assign src = i_issue.src_a;
   assign other = i_issue.src_b;

   // ************************************************************
   // compare and select
   // ************************************************************
   logic [7:0] src_lt_imm;
   logic [7:0] imm_lt_src;
   logic [7:0] src_lt_other;
   logic [63:0] lt_mask;
   logic [63:0] le_mask;
   logic [63:0] max_mask;

   // unsigned chunk compares; less-or-equal is not greater
   always_comb begin
      src_lt_imm = chunk_below(src, imm_wide, chunk_top);
      imm_lt_src = chunk_below(imm_wide, src, chunk_top);
      src_lt_other = chunk_below(src, other, chunk_top);
      lt_mask = spread(src_lt_imm, chunk_top);
      le_mask = ~spread(imm_lt_src, chunk_top);
      max_mask = spread(src_lt_other, chunk_top);
   end

   // ************************************************************
   // negation by chunk
   // ************************************************************
   logic [63:0] neg_val;
   logic [63:0] sign_mask;

   // two's complement per chunk; wraps on the most negative value
   always_comb begin
      logic carry;
      carry = 1'b1;
      neg_val = '0;
      for (int k = 0; k < 8; k++) begin
         if (chunk_base[k]) begin
            carry = 1'b1;
         end
         {carry, neg_val[k*8 +: 8]} = {1'b0, ~src[k*8 +: 8]} +
            {8'h00, carry};
      end
      sign_mask = spread({src[63], src[55], src[47], src[39],
         src[31], src[23], src[15], src[7]}, chunk_top);
   end

   // ************************************************************
   // result selection
   // ************************************************************
   logic [63:0] next_data;
   logic next_cancel;

   always_comb begin
      next_data = src;
      next_cancel = 1'b0;
      case (op)
         INCU_OP_BELOW_IMM: next_data = lt_mask;
         INCU_OP_BELOW_EQ_IMM: next_data = le_mask;
         INCU_OP_MAGNITUDE: begin
            // per-chunk choice; scalar non-negative cancels instead
            next_data = (neg_val & sign_mask) | (src & ~sign_mask);
            if (!simd && !src[63]) begin
               next_cancel = 1'b1;
            end
         end
         INCU_OP_NEG_MAGNITUDE: begin
            next_data = (src & sign_mask) | (neg_val & ~sign_mask);
         end
         INCU_OP_LARGER_SELECT: begin
            next_data = (other & max_mask) | (src & ~max_mask);
         end
         default: next_data = src;
      endcase
   end

   // ************************************************************
   // write-back register, one cycle after issue
   // ************************************************************
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_result <= '0;
      end else begin
         o_result.valid <= i_issue.valid && (op != INCU_OP_NONE);
         o_result.cancel <= next_cancel;
         o_result.dest <= dest;
         o_result.data <= next_data;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   property p_latency;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_issue.valid && op != INCU_OP_NONE) |=> o_result.valid;
   endproperty
   a_latency: assert property (p_latency) else $error("result late");

   property p_below_scalar;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_issue.valid && op == INCU_OP_BELOW_IMM && !simd)
      |=> o_result.data ==
         {64{$past(src) < {56'h0, $past(eight_bit_constant)}}};
   endproperty
   a_below_scalar: assert property (p_below_scalar) else $error("lt");

   property p_le_scalar;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_issue.valid && op == INCU_OP_BELOW_EQ_IMM && !simd)
      |=> o_result.data ==
         {64{$past(src) <= {56'h0, $past(eight_bit_constant)}}};
   endproperty
   a_le_scalar: assert property (p_le_scalar) else $error("cmple bad");

   property p_abs_cancel;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_issue.valid && op == INCU_OP_MAGNITUDE && !simd)
      |=> o_result.cancel == !$past(src[63]);
   endproperty
   a_abs_cancel: assert property (p_abs_cancel) else $error("cancel");

   property p_abs_simd;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_issue.valid && op == INCU_OP_MAGNITUDE && simd) |=> !o_result.cancel;
   endproperty
   a_abs_simd: assert property (p_abs_simd) else $error("simd cancel");

   property p_abs_wrap;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_issue.valid && op == INCU_OP_MAGNITUDE && !simd && src[63])
      |=> o_result.data == 64'h0 - $past(src);
   endproperty
   a_abs_wrap: assert property (p_abs_wrap) else $error("neg bad");

   property p_nabs_pass;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_issue.valid && op == INCU_OP_NEG_MAGNITUDE && !simd && src[63])
      |=> o_result.data == $past(src);
   endproperty
   a_nabs_pass: assert property (p_nabs_pass) else $error("nabs bad");

   property p_max_scalar;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_issue.valid && op == INCU_OP_LARGER_SELECT && !simd)
      |=> o_result.data == (($past(src) < $past(other)) ? $past(other)
         : $past(src));
   endproperty
   a_max_scalar: assert property (p_max_scalar) else $error("max bad");

   // named steps: the taking edge of a negative-magnitude issue and of an unknown-opcode issue
   sequence s_take_neg_magnitude;
      i_issue.valid && op == INCU_OP_NEG_MAGNITUDE;
   endsequence

   sequence s_take_unknown;
      i_issue.valid && op == INCU_OP_NONE;
   endsequence

   // non-negative scalar source is negated, zero stays zero
   property p_nabs_negate;
      @(posedge i_clock) disable iff (!i_rst_n)
      s_take_neg_magnitude ##0 (!simd && !src[63])
      |=> o_result.data == 64'h0 - $past(src);
   endproperty
   a_nabs_negate: assert property (p_nabs_negate) else $error("nabs");

   // negative magnitude always writes back, scalar or SIMD
   property p_nabs_keep;
      @(posedge i_clock) disable iff (!i_rst_n)
      s_take_neg_magnitude |=> !o_result.cancel;
   endproperty
   a_nabs_keep: assert property (p_nabs_keep) else $error("kept");

   // an opcode outside this slice never produces a result
   property p_refused;
      @(posedge i_clock) disable iff (!i_rst_n)
      s_take_unknown |=> !o_result.valid;
   endproperty
   a_refused: assert property (p_refused) else $error("refused bad");
endmodule
`default_nettype wire

// >>> incu_pkg.sv
// package: instruction fields, opcodes, size codes and carrier structs
package incu_pkg;
   // ************************************************************
   // widths and instruction fields
   // ************************************************************
   localparam int DATA_W = 64;
   localparam int OPC_HI = 31;
   localparam int OPC_LO = 24;
   localparam int SIZE_HI = 23;
   localparam int SIZE_LO = 22;
   localparam int SIMD_BIT = 21;
   localparam int IMM_HI = 19;
   localparam int IMM_LO = 12;
   localparam int SRC_HI = 11;
   localparam int SRC_LO = 6;
   localparam int DST_HI = 5;
   localparam int DST_LO = 0;
   localparam int LATENCY_CYCLES = 1;
   // ************************************************************
   // opcodes: values arbitrary, the decoder shares this package
   // ************************************************************
   localparam logic [7:0] OPC_BELOW_IMM = 8'h30;
   localparam logic [7:0] OPC_BELOW_EQ_IMM = 8'h31;
   localparam logic [7:0] OPC_MAGNITUDE = 8'h32;
   localparam logic [7:0] OPC_NEG_MAGNITUDE = 8'h33;
   localparam logic [7:0] OPC_LARGER_SELECT = 8'h34;
   // ************************************************************
   // chunk size codes
   // ************************************************************
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [1:0] SIZE_QUAD = 2'h3;

   typedef enum logic [2:0] {
      INCU_OP_NONE,
      INCU_OP_BELOW_IMM,
      INCU_OP_BELOW_EQ_IMM,
      INCU_OP_MAGNITUDE,
      INCU_OP_NEG_MAGNITUDE,
      INCU_OP_LARGER_SELECT
   } incu_op_t;

   typedef struct packed {
      logic valid;
      logic [31:0] instr;
      logic [DATA_W-1:0] src_a;
      logic [DATA_W-1:0] src_b;
   } incu_issue_t;

   typedef struct packed {
      logic valid;
      logic cancel;
      logic [5:0] dest;
      logic [DATA_W-1:0] data;
   } incu_result_t;
endpackage

// >>> incu_decode.sv
// instruction field decoder for the increment compare/abs/max slice
`timescale 1ns/1ps
`default_nettype none
module incu_decode
   import incu_pkg::*;
(
   input wire logic [31:0] i_instr,
   output incu_pkg::incu_op_t o_op,
   output logic [1:0] o_size,
   output logic o_simd,
   output logic [7:0] o_eight_bit_constant,
   output logic [5:0] o_dest
);
   // field split; reserved flag bits are left unread
   always_comb begin
      o_size = i_instr[SIZE_HI:SIZE_LO];
      o_simd = i_instr[SIMD_BIT];
      o_eight_bit_constant = i_instr[IMM_HI:IMM_LO];
      o_dest = i_instr[DST_HI:DST_LO];
      case (i_instr[OPC_HI:OPC_LO])
         OPC_BELOW_IMM: o_op = INCU_OP_BELOW_IMM;
         OPC_BELOW_EQ_IMM: o_op = INCU_OP_BELOW_EQ_IMM;
         OPC_MAGNITUDE: o_op = INCU_OP_MAGNITUDE;
         OPC_NEG_MAGNITUDE: o_op = INCU_OP_NEG_MAGNITUDE;
         OPC_LARGER_SELECT: o_op = INCU_OP_LARGER_SELECT;
         default: o_op = INCU_OP_NONE;
      endcase
   end
endmodule
`default_nettype wire

// >>> incu_lane_mask.sv
// per-byte lane flags marking the top and bottom byte of each chunk
`timescale 1ns/1ps
`default_nettype none
module incu_lane_mask
   import incu_pkg::*;
(
   input wire logic [1:0] i_size,
   input wire logic i_simd,
   output logic [7:0] o_chunk_top,
   output logic [7:0] o_chunk_base
);
   // scalar always works on the full word, whatever the size code
   always_comb begin
      o_chunk_top = 8'h80;
      o_chunk_base = 8'h01;
      if (i_simd) begin
         case (i_size)
            SIZE_BYTE: begin
               o_chunk_top = 8'hff;
               o_chunk_base = 8'hff;
            end
            SIZE_HALF: begin
               o_chunk_top = 8'haa;
               o_chunk_base = 8'h55;
            end
            SIZE_WORD: begin
               o_chunk_top = 8'h88;
               o_chunk_base = 8'h11;
            end
            default: begin
               o_chunk_top = 8'h80;
               o_chunk_base = 8'h01;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> incu_regfile_model.sv
// register file model on the write-back side of the unit
`timescale 1ns/1ps
`default_nettype none
module incu_regfile_model
   import incu_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire incu_pkg::incu_result_t i_result,
   input wire logic [5:0] i_peek_idx,
   output logic [DATA_W-1:0] o_peek
);
   // ************************************************************
   // storage and write-back
   // ************************************************************
   logic [DATA_W-1:0] regs [64];

   // a cancelled result must leave the old value in place
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < 64; i++) begin
            regs[i] <= 64'h5a5a5a5a5a5a5a5a ^ 64'(i);
         end
      end else if (i_result.valid && !i_result.cancel) begin
         regs[i_result.dest] <= i_result.data;
      end
   end

   // read port for the bench, no latency
   assign o_peek = regs[i_peek_idx];
endmodule
`default_nettype wire

// >>> incu_cmp_abs_max_tb.sv
// testbench: issues instructions, checks results and write-back
`timescale 1ns/1ps
`default_nettype none
module incu_cmp_abs_max_tb;
   import incu_pkg::*;
   // ************************************************************
   // signals
   // ************************************************************
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   incu_issue_t issue = '0;
   incu_result_t result;
   logic [5:0] peek_idx = '0;
   logic [63:0] peek;
   logic [63:0] shadow [64];
   logic [5:0] dst = '0;
   logic [7:0] ops [5] = '{OPC_BELOW_IMM, OPC_BELOW_EQ_IMM, OPC_MAGNITUDE,
      OPC_NEG_MAGNITUDE, OPC_LARGER_SELECT};
   int n_mismatch = 0;
   int samples_checked = 0;

   // 10 MHz core clock
   always #50 i_clock = ~i_clock;

   incu_cmp_abs_max i_incu_cmp_abs_max (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_issue(issue),
      .o_result(result)
   );

   incu_regfile_model i_incu_regfile_model (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_result(result),
      .i_peek_idx(peek_idx),
      .o_peek(peek)
   );

   // ************************************************************
   // tasks
   // ************************************************************
   task automatic chk(string name, logic [63:0] exp, logic [63:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // reference result, chunk by chunk; top bit is the cancel flag
   function automatic logic [64:0] predict(logic [7:0] opc, logic [1:0] sz,
      logic simd, logic [7:0] imm, logic [63:0] a, logic [63:0] b);
      int w;
      logic [63:0] m, ca, cb, r, res;
      logic cancel;
      w = simd ? (8 << sz) : 64;
      m = (w == 64) ? '1 : ((64'h1 << w) - 64'h1);
      res = '0;
      cancel = 1'b0;
      for (int s = 0; s < 64; s += w) begin
         ca = (a >> s) & m;
         cb = (b >> s) & m;
         case (opc)
            OPC_BELOW_IMM: r = (ca < {56'h0, imm}) ? m : '0;
            OPC_BELOW_EQ_IMM: r = (ca <= {56'h0, imm}) ? m : '0;
            OPC_MAGNITUDE: r = ca[w-1] ? ((-ca) & m) : ca;
            OPC_NEG_MAGNITUDE: r = ca[w-1] ? ca : ((-ca) & m);
            default: r = (ca < cb) ? cb : ca;
         endcase
         if (opc == OPC_MAGNITUDE && !simd && !ca[w-1]) begin
            cancel = 1'b1;
         end
         res = res | (r << s);
      end
      return {cancel, res};
   endfunction

   // one instruction: drive, take, check result, then write-back
   task automatic run(logic [7:0] opc, logic [1:0] sz, logic simd,
      logic [7:0] fld, logic [63:0] a, logic [63:0] b);
      logic [64:0] e;
      logic [7:0] f;
      // magnitude forms must carry zero in bits 19-12
      f = (opc == OPC_MAGNITUDE || opc == OPC_NEG_MAGNITUDE) ? 8'h00 : fld;
      e = predict(opc, sz, simd, f, a, b);
      @(posedge i_clock);
      issue <= {1'b1, opc, sz, simd, 1'b0, f, 6'h01, dst, a, b};
      peek_idx <= dst;
      repeat (LATENCY_CYCLES) @(posedge i_clock);
      issue.valid <= 1'b0;
      #1;
      chk("valid", 64'h1, {63'h0, result.valid});
      chk("dest", {58'h0, dst}, {58'h0, result.dest});
      chk("cancel", {63'h0, e[64]}, {63'h0, result.cancel});
      if (!e[64]) begin
         chk("data", e[63:0], result.data);
         shadow[dst] = e[63:0];
      end
      @(posedge i_clock);
      #1;
      chk("pulse", 64'h0, {63'h0, result.valid});
      chk("regfile", shadow[dst], peek);
      dst = dst + 6'h1;
   endtask

   // ************************************************************
   // sequence
   // ************************************************************
   // hang guard
   initial begin
      repeat (3000) @(posedge i_clock);
      n_mismatch++;
      $display("ERROR watchdog expected end seen hang");
      give_verdict;
   end

   // directed cases, then a sweep of every opcode, size and mode
   initial begin
      for (int i = 0; i < 64; i++) begin
         shadow[i] = 64'h5a5a5a5a5a5a5a5a ^ 64'(i);
      end
      repeat (20) @(posedge i_clock);
      chk("reset", 64'h0, {63'h0, result.valid} | result.data);
      i_rst_n <= 1'b1;
      run(OPC_BELOW_IMM, SIZE_QUAD, 1'b0, 8'h06, 64'h5, '0);
      run(OPC_BELOW_IMM, SIZE_QUAD, 1'b0, 8'h06, 64'h6, '0);
      run(OPC_BELOW_IMM, SIZE_BYTE, 1'b0, 8'hff, '1, '0);
      run(OPC_BELOW_EQ_IMM, SIZE_QUAD, 1'b0, 8'h06, 64'h6, '0);
      run(OPC_BELOW_EQ_IMM, SIZE_QUAD, 1'b0, 8'h06, 64'h7, '0);
      run(OPC_BELOW_IMM, SIZE_BYTE, 1'b1, 8'h04,
         64'h0000000500000003, '0);
      run(OPC_BELOW_EQ_IMM, SIZE_HALF, 1'b1, 8'h80,
         64'hff0000ff00800000, '0);
      run(OPC_MAGNITUDE, SIZE_QUAD, 1'b0, 8'h00,
         64'hfffffffffffffffb, '0);
      run(OPC_MAGNITUDE, SIZE_QUAD, 1'b0, 8'h00, 64'h5, '0);
      run(OPC_MAGNITUDE, SIZE_BYTE, 1'b0, 8'h00,
         64'h8000000000000000, '0);
      run(OPC_MAGNITUDE, SIZE_BYTE, 1'b1, 8'h00,
         64'hff05891213450180, '0);
      run(OPC_NEG_MAGNITUDE, SIZE_QUAD, 1'b0, 8'h00,
         64'hff05891213450100, '0);
      run(OPC_NEG_MAGNITUDE, SIZE_QUAD, 1'b0, 8'h00, 64'h0, '0);
      run(OPC_LARGER_SELECT, SIZE_BYTE, 1'b1, 8'h02,
         64'h0000000500000003, 64'h0000000700000001);
      run(OPC_LARGER_SELECT, SIZE_QUAD, 1'b0, 8'h02, '1, 64'h1);
      for (int o = 0; o < 5; o++) begin
         for (int z = 0; z < 4; z++) begin
            for (int v = 0; v < 2; v++) begin
               run(ops[o], 2'(z), v[0], 8'h12, 64'hff05891213450100,
                  64'h80057f0013460201);
            end
         end
      end
      // reset in mid-run clears a result that was non-zero
      @(posedge i_clock);
      i_rst_n <= 1'b0;
      @(posedge i_clock);
      #1;
      chk("midreset", 64'h0, {63'h0, result.valid} | result.data);
      @(posedge i_clock);
      i_rst_n <= 1'b1;
      // an unknown opcode must give no result
      @(posedge i_clock);
      issue <= {1'b1, 8'h00, 24'h000041, 64'h1, 64'h2};
      @(posedge i_clock);
      issue.valid <= 1'b0;
      #1;
      chk("refused", 64'h0, {63'h0, result.valid});
      give_verdict;
   end
endmodule
`default_nettype wire
